// [inc/twowire_amp_consts.svh]
/*
 * Shared constants for the amplifier gain-control two-wire target and its master.
 * Assumes it is included by bare name from files on the inc/ search path.
 */
`ifndef TWOWIRE_AMP_CONSTS_SVH
`define TWOWIRE_AMP_CONSTS_SVH

// Target's fixed seven-bit bus address.
`define TGT_ADDR 7'h2a

// Register index of the target's registers.
`define GAIN_STATUS_OFS 8'h04
`define VOLUME_OFS 8'h1b
`define GAIN_STATUS_RST 5'h01
`define VOLUME_RST 6'h00
`define VOLUME_MUTE 6'h3f
`define VOLUME_LAST_LISTED 6'h1f

// Master's own register map on APB, byte addresses.
`define HOST_CMD_OFS 8'h00
`define HOST_INDEX_OFS 8'h04
`define HOST_WDATA_OFS 8'h08
`define HOST_STATUS_OFS 8'h0c
`define HOST_CMD_GO_BIT 0
`define HOST_CMD_READ_BIT 1
`define HOST_STAT_BUSY_BIT 0
`define HOST_STAT_NACK_BIT 1

// Timing: pclk rate and fastest serial clock, both in kHz.
`define PCLK_KHZ 40000
`define SCL_KHZ 400
// A quarter of the serial clock period, rounded up so the rate never exceeds SCL_KHZ.
`define SCL_QTR_CYC ((`PCLK_KHZ + 4 * `SCL_KHZ - 1) / (4 * `SCL_KHZ))

`endif

// [inc/twowire_amp_pkg.sv]
/*
 * Types shared by the two-wire target and master.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package twowire_amp_pkg;

    // Eleven bits so the deepest attenuation, -62 dB in tenths, still fits.
    typedef logic signed [10:0] gain_t;

    typedef enum logic [2:0]
    {
        ts_idle = 3'b000,
        ts_rx = 3'b001,
        ts_ack = 3'b010,
        ts_tx = 3'b011,
        ts_mack = 3'b100
    } target_state_t;

    typedef enum logic [1:0]
    {
        bp_addr = 2'b00,
        bp_index = 2'b01,
        bp_data = 2'b10
    } byte_phase_t;

    typedef enum logic [1:0]
    {
        el_start = 2'b00,
        el_tx = 2'b01,
        el_rx = 2'b10,
        el_stop = 2'b11
    } element_t;

endpackage

// [inc/twowire_link_if.sv]
/*
 * Two-wire link joining the master and the amplifier target.
 * Assumes both ends drive open drain: a pin is low only while its enable is high and its
 * output is low; otherwise the pull-up holds it high.
 */
`timescale 1ns/1ps
`default_nettype none

interface twowire_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // A line that no end pulls low resolves high here, as a pull-up would hold it.
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

    modport device
    (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host
    (
        input scl,
        input sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface

`default_nettype wire

// [rtl/amp_gain_target.sv]
/*
 * Two-wire target of the stereo amplifier: strap decode, volume register and gain lookup.
 * Assumes the serial lines and the strap arrive asynchronously to pclk and that the
 * serial clock is at most a tenth of pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twowire_amp_consts.svh"

// Notes on behaviour
// - Strap decodes to one of five gains.
// - Status register 0x04 is one-hot, read-only.
// - Volume register 0x1B holds six-bit code.
// - At 0 dB strap, 2 dB steps.
// - Code 0x3F mutes; strap and code combine.
// - At 24 dB strap, only zero or mute.
// - Target only; never drives serial clock.
// - START and STOP framed by data edges.
// - STOP returns interface to idle.
// - Target as receiver pulls data low on ninth clock.
// - Address byte: seven bits, then direction.
// - Acknowledge only address 0101010.
// - Write: address, index, data, stop.
// - Index byte selects target register.
// - Read: index write, repeated start, read.
// - Master leaves the read data byte unacknowledged.
// - Works with serial clock to 400 kHz.
// - Open-drain lines with weak pull-up.
module amp_gain_target #(
    parameter logic [6:0] TARGET_ADDR = `TGT_ADDR
)
(
    input wire logic pclk,
    input wire logic presetn,
    twowire_link_if.device link,
    input wire logic [2:0] gain_strap_pin,
    output logic [4:0] strap_gain_decode,
    output logic [5:0] volume_code,
    output logic out_mute,
    output logic gain_valid,
    output twowire_amp_pkg::gain_t gain_tenth_db
);
    import twowire_amp_pkg::*;

    // Gain in tenths of a dB for the 6, 12 and 18 dB strap columns, by volume code.
    localparam gain_t COL6 [0:31] = '{
        11'sd60, 11'sd41, 11'sd22, 11'sd4, -11'sd16, -11'sd35, -11'sd56, -11'sd75,
        -11'sd95, -11'sd114, -11'sd134, -11'sd154, -11'sd173, -11'sd193, -11'sd213, -11'sd233,
        -11'sd253, -11'sd273, -11'sd291, -11'sd307, -11'sd322, -11'sd337, -11'sd351, -11'sd366,
        -11'sd360, -11'sd352, -11'sd346, -11'sd342, -11'sd339, -11'sd337, -11'sd335, -11'sd334};
    localparam gain_t COL12 [0:31] = '{
        11'sd120, 11'sd104, 11'sd88, 11'sd71, 11'sd54, 11'sd36, 11'sd17, -11'sd2,
        -11'sd20, -11'sd39, -11'sd58, -11'sd78, -11'sd97, -11'sd117, -11'sd136, -11'sd156,
        -11'sd176, -11'sd193, -11'sd204, -11'sd205, -11'sd202, -11'sd200, -11'sd198, -11'sd197,
        -11'sd196, -11'sd195, -11'sd195, -11'sd194, -11'sd194, -11'sd194, -11'sd194, -11'sd193};
    localparam gain_t COL18 [0:31] = '{
        11'sd180, 11'sd170, 11'sd160, 11'sd150, 11'sd137, 11'sd124, 11'sd109, 11'sd94,
        11'sd79, 11'sd62, 11'sd45, 11'sd27, 11'sd9, -11'sd9, -11'sd28, -11'sd47,
        -11'sd66, -11'sd73, -11'sd73, -11'sd72, -11'sd71, -11'sd71, -11'sd71, -11'sd71,
        -11'sd70, -11'sd70, -11'sd70, -11'sd70, -11'sd70, -11'sd70, -11'sd70, -11'sd70};
    localparam gain_t GAIN_24 = 11'sd240;

    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic [2:0] strap_s1, strap_s2;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    target_state_t state;
    byte_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic byte_done;
    logic rd_dir;
    logic sda_drive;
    logic [7:0] reg_index;
    logic [7:0] read_byte;
    logic vol_we;
    logic next_valid, next_mute;
    gain_t next_gain;

    // Two stages on every pin before any logic looks at it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
        end
        else
        begin
            scl_s1 <= link.scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            strap_s1 <= gain_strap_pin;
            strap_s2 <= strap_s1;
        end
    end

    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;

    // Position codes above four are read as the floating, 0 dB position.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_gain_decode <= `GAIN_STATUS_RST;
        else if (strap_s2 <= 3'h4)
            strap_gain_decode <= 5'h01 << strap_s2;
        else
            strap_gain_decode <= 5'h01;
    end

    always_comb
    begin
        unique case (reg_index)
            `GAIN_STATUS_OFS: read_byte = {3'h0, strap_gain_decode};
            `VOLUME_OFS: read_byte = {2'h0, volume_code};
            default: read_byte = 8'h00;
        endcase
    end

    // The status register has no write path, so writes to it are dropped.
    assign vol_we = (state == ts_rx) && scl_fall && byte_done && (phase == bp_data)
        && (reg_index == `VOLUME_OFS);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            volume_code <= `VOLUME_RST;
        else if (vol_we)
            volume_code <= rx_sh[5:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reg_index <= 8'h00;
        else if ((state == ts_rx) && scl_fall && byte_done && (phase == bp_index))
            reg_index <= rx_sh;
    end

    // Byte engine. Only the data line is ever driven; the clock is input only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ts_idle;
            phase <= bp_addr;
            bitcnt <= 4'h0;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            byte_done <= 1'b0;
            rd_dir <= 1'b0;
            sda_drive <= 1'b0;
        end
        else if (start_seen)
        begin
            // A repeated start lands here too and keeps the register index.
            state <= ts_rx;
            phase <= bp_addr;
            bitcnt <= 4'h0;
            byte_done <= 1'b0;
            sda_drive <= 1'b0;
        end
        else if (stop_seen)
        begin
            state <= ts_idle;
            sda_drive <= 1'b0;
        end
        else
        begin
            unique case (state)
                ts_idle:
                begin
                    sda_drive <= 1'b0;
                end
                ts_rx:
                begin
                    if (scl_rise && !byte_done)
                    begin
                        rx_sh <= {rx_sh[6:0], sda_s2};
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == 4'h7)
                            byte_done <= 1'b1;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        byte_done <= 1'b0;
                        bitcnt <= 4'h0;
                        if ((phase == bp_addr) && (rx_sh[7:1] != TARGET_ADDR))
                            state <= ts_idle;
                        else
                        begin
                            if (phase == bp_addr)
                                rd_dir <= rx_sh[0];
                            sda_drive <= 1'b1;
                            state <= ts_ack;
                        end
                    end
                end
                ts_ack:
                begin
                    if (scl_fall)
                    begin
                        bitcnt <= 4'h0;
                        if ((phase == bp_addr) && rd_dir)
                        begin
                            tx_sh <= read_byte;
                            sda_drive <= ~read_byte[7];
                            state <= ts_tx;
                        end
                        else
                        begin
                            sda_drive <= 1'b0;
                            phase <= (phase == bp_addr) ? bp_index : bp_data;
                            state <= ts_rx;
                        end
                    end
                end
                ts_tx:
                begin
                    if (scl_rise)
                        bitcnt <= bitcnt + 4'h1;
                    else if (scl_fall)
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            sda_drive <= 1'b0;
                            state <= ts_mack;
                        end
                        else
                        begin
                            tx_sh <= {tx_sh[6:0], 1'b0};
                            sda_drive <= ~tx_sh[6];
                        end
                    end
                end
                ts_mack:
                begin
                    // The master's answer decides whether the byte is sent again.
                    if (scl_rise)
                        state <= sda_s2 ? ts_idle : ts_ack;
                end
                default:
                begin
                    state <= ts_idle;
                    sda_drive <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: the pin is only ever pulled low.
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_drive;

    // Unlisted codes 0x20 to 0x3E, and non-zero codes other than mute at the 24 dB strap, are flagged invalid.
    always_comb
    begin
        next_mute = (volume_code == `VOLUME_MUTE);
        next_valid = 1'b1;
        next_gain = 11'sd0;
        if (next_mute || (volume_code > `VOLUME_LAST_LISTED))
            next_valid = next_mute;
        else
        begin
            unique case (strap_gain_decode)
                5'h02: next_gain = COL6[volume_code[4:0]];
                5'h04: next_gain = COL12[volume_code[4:0]];
                5'h08: next_gain = COL18[volume_code[4:0]];
                5'h10:
                begin
                    next_gain = GAIN_24;
                    next_valid = (volume_code == 6'h00);
                end
                default: next_gain = -gain_t'({volume_code[4:0], 1'b0}) * 11'sd10;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_mute <= 1'b0;
            gain_valid <= 1'b1;
            gain_tenth_db <= 11'sd0;
        end
        else
        begin
            out_mute <= next_mute;
            gain_valid <= next_valid;
            gain_tenth_db <= next_gain;
        end
    end
endmodule

`default_nettype wire

// [rtl/twowire_master_apb.sv]
/*
 * Two-wire bus master ordered over APB: one register write or one register read per command.
 * Assumes a single target that never stretches the clock; the line inputs are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twowire_amp_consts.svh"

module twowire_master_apb #(
    parameter logic [6:0] TARGET_ADDR = `TGT_ADDR,
    parameter int QTR = `SCL_QTR_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    twowire_link_if.host link
);
    import twowire_amp_pkg::*;

    logic sda_s1, sda_s2;
    logic busy, rd_cmd, nack;
    logic [7:0] index_reg, wdata_reg, rdata_reg;
    logic [2:0] step;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic tick, go, wr_en, mapped, bit_end;
    logic scl_rel, sda_rel;
    element_t elem;
    logic [2:0] stop_step;

    assign mapped = (paddr == `HOST_CMD_OFS) || (paddr == `HOST_INDEX_OFS)
        || (paddr == `HOST_WDATA_OFS) || (paddr == `HOST_STATUS_OFS);
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite & mapped;
    // Commands while busy are dropped; software polls the busy bit first.
    assign go = wr_en && (paddr == `HOST_CMD_OFS) && pwdata[`HOST_CMD_GO_BIT] && !busy;

    // Read data is captured in the setup cycle so the bus sees a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr <= !mapped;
            unique case (paddr)
                `HOST_INDEX_OFS: prdata <= {24'h00_0000, index_reg};
                `HOST_WDATA_OFS: prdata <= {24'h00_0000, wdata_reg};
                `HOST_STATUS_OFS: prdata <= {16'h0000, rdata_reg, 6'h00, nack, busy};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            index_reg <= 8'h00;
            wdata_reg <= 8'h00;
        end
        else if (wr_en && !busy)
        begin
            if (paddr == `HOST_INDEX_OFS)
                index_reg <= pwdata[7:0];
            if (paddr == `HOST_WDATA_OFS)
                wdata_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end
        else
        begin
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
        end
    end

    // Element sequence of a write and of a read.
    always_comb
    begin
        stop_step = rd_cmd ? 3'd6 : 3'd4;
        unique case (step)
            3'd0: elem = el_start;
            3'd3: elem = rd_cmd ? el_start : el_tx;
            3'd5: elem = rd_cmd ? el_rx : el_stop;
            3'd6: elem = el_stop;
            3'd4: elem = rd_cmd ? el_tx : el_stop;
            default: elem = el_tx;
        endcase
        unique case (elem)
            el_start:
            begin
                scl_rel = (ph == 2'd1) || (ph == 2'd2);
                sda_rel = (ph < 2'd2);
            end
            el_stop:
            begin
                scl_rel = (ph != 2'd0);
                sda_rel = (ph >= 2'd2);
            end
            el_tx:
            begin
                scl_rel = ph[1];
                sda_rel = (bitn == 4'd8) ? 1'b1 : sh[7];
            end
            default:
            begin
                scl_rel = ph[1];
                sda_rel = 1'b1;
            end
        endcase
    end

    assign tick = (qcnt == 8'(QTR - 1));
    assign bit_end = tick && (ph == 2'd3);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            rd_cmd <= 1'b0;
            nack <= 1'b0;
            rdata_reg <= 8'h00;
            step <= 3'd0;
            ph <= 2'd0;
            qcnt <= 8'h00;
            bitn <= 4'h0;
            sh <= 8'h00;
        end
        else if (!busy)
        begin
            if (go)
            begin
                busy <= 1'b1;
                rd_cmd <= pwdata[`HOST_CMD_READ_BIT];
                nack <= 1'b0;
                step <= 3'd0;
                ph <= 2'd0;
                qcnt <= 8'h00;
                bitn <= 4'h0;
            end
        end
        else
        begin
            qcnt <= tick ? 8'h00 : qcnt + 8'h01;
            if (tick)
                ph <= ph + 2'd1;
            if (tick && (ph == 2'd2) && (elem == el_tx) && (bitn == 4'd8) && sda_s2)
                nack <= 1'b1;
            if (tick && (ph == 2'd2) && (elem == el_rx) && (bitn < 4'd8))
                rdata_reg <= {rdata_reg[6:0], sda_s2};
            if (bit_end)
            begin
                if ((elem == el_start) || (elem == el_stop) || (bitn == 4'd8))
                begin
                    bitn <= 4'h0;
                    if (elem == el_stop)
                        busy <= 1'b0;
                    else if ((elem == el_tx) && nack)
                        step <= stop_step;
                    else
                        step <= step + 3'd1;
                    // Load the next byte to send; only the tx steps use it.
                    unique case (step)
                        3'd0: sh <= {TARGET_ADDR, 1'b0};
                        3'd1: sh <= index_reg;
                        3'd2: sh <= wdata_reg;
                        default: sh <= {TARGET_ADDR, 1'b1};
                    endcase
                end
                else
                begin
                    bitn <= bitn + 4'h1;
                    if (bitn < 4'd7)
                        sh <= {sh[6:0], 1'b0};
                end
            end
        end
    end

    // Pins are only ever pulled low.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.host_scl_oe <= 1'b0;
            link.host_sda_oe <= 1'b0;
        end
        else
        begin
            link.host_scl_oe <= busy & ~scl_rel;
            link.host_sda_oe <= busy & ~sda_rel;
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_sda_o = 1'b0;
endmodule

`default_nettype wire

// [verif/tb_amp_gain_control_twowire_slave.sv]
/*
 * Bench: APB-ordered master and amplifier target joined by the link; a second pair uses
 * a wrong address. Assumes the master's default divider, so a byte takes 900 pclk cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twowire_amp_consts.svh"

module tb_amp_gain_control_twowire_slave;
    import twowire_amp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [1:0] psel = 2'h0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata [2];
    logic pready [2];
    logic pslverr [2];
    logic [2:0] strap = 3'h0;
    logic [4:0] dec;
    logic [5:0] vol;
    logic [5:0] vol2;
    logic mute;
    logic valid;
    gain_t gain;
    int miscompares = 0;
    int checks_done = 0;
    twowire_link_if lk();
    twowire_link_if lk2();

    // The default divider keeps the serial clock at 400 kHz, inside the rated range.
    twowire_master_apb twowire_master_apb_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel[0]), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]), .link(lk));
    amp_gain_target amp_gain_target_inst (.pclk(pclk), .presetn(presetn), .link(lk),
        .gain_strap_pin(strap), .strap_gain_decode(dec), .volume_code(vol),
        .out_mute(mute), .gain_valid(valid), .gain_tenth_db(gain));
    // The second master calls a neighbouring address, so the target must stay silent.
    twowire_master_apb #(.TARGET_ADDR(7'h2b)) twowire_master_apb_inst2 (
        .pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata[1]),
        .pready(pready[1]), .pslverr(pslverr[1]), .link(lk2));
    amp_gain_target amp_gain_target_inst2 (.pclk(pclk), .presetn(presetn), .link(lk2),
        .gain_strap_pin(3'h0), .strap_gain_decode(), .volume_code(vol2),
        .out_mute(), .gain_valid(), .gain_tenth_db());
    twowire_link_asserts twowire_link_asserts_inst (.pclk(pclk), .presetn(presetn),
        .host_scl_o(lk.host_scl_o), .host_scl_oe(lk.host_scl_oe),
        .host_sda_o(lk.host_sda_o), .host_sda_oe(lk.host_sda_oe),
        .dev_sda_o(lk.dev_sda_o), .dev_sda_oe(lk.dev_sda_oe), .scl(lk.scl), .sda(lk.sda));

    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_up;
        miscompares++;
        $display("ERROR %0t wait ran out", $time);
        wrap_up;
    endtask

    task automatic apb(input int m, input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel[m] <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready[m] !== 1'b1 && n < 20);
        if (pready[m] !== 1'b1)
            give_up;
        r = prdata[m];
        psel[m] <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic op(input int m, input logic rd, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] st);
        int n;
        n = 0;
        apb(m, 1'b1, `HOST_INDEX_OFS, {24'h0, idx}, st);
        apb(m, 1'b1, `HOST_WDATA_OFS, {24'h0, wd}, st);
        apb(m, 1'b1, `HOST_CMD_OFS, {30'h0, rd, 1'b1}, st);
        do
        begin
            apb(m, 1'b0, `HOST_STATUS_OFS, 32'h0, st);
            n++;
        end
        while (st[0] !== 1'b0 && n < 2000);
        if (st[0] !== 1'b0)
            give_up;
    endtask

    initial
    begin
        logic [31:0] st;
        int s;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(vol, `VOLUME_RST);
        for (s = 0; s < 5; s++)
        begin
            strap <= 3'(s);
            op(0, 1'b1, `GAIN_STATUS_OFS, 8'h00, st);
            chk(st[15:8], 8'h01 << s);
            chk(st[1], 1'b0);
            chk(dec, 5'h01 << s);
            chk(gain, 60 * s);
            chk(valid, 1'b1);
        end
        op(0, 1'b0, `GAIN_STATUS_OFS, 8'h01, st);
        op(0, 1'b1, `GAIN_STATUS_OFS, 8'h00, st);
        chk(st[15:8], 8'h10);
        strap <= 3'h0;
        op(0, 1'b0, `VOLUME_OFS, 8'h05, st);
        chk(vol, 6'h05);
        chk(gain, -100);
        chk(mute, 1'b0);
        op(0, 1'b1, `VOLUME_OFS, 8'h00, st);
        chk(st[15:8], 8'h05);
        chk(st[1], 1'b0);
        op(0, 1'b0, `VOLUME_OFS, `VOLUME_LAST_LISTED, st);
        chk(gain, -620);
        op(0, 1'b0, `VOLUME_OFS, `VOLUME_MUTE, st);
        strap <= 3'h2;
        repeat (5) @(posedge pclk);
        chk(mute, 1'b1);
        chk(gain, 0);
        chk(valid, 1'b1);
        op(1, 1'b0, `VOLUME_OFS, 8'h07, st);
        chk(st[1], 1'b1);
        chk(vol2, `VOLUME_RST);
        apb(0, 1'b0, 8'h10, 32'h0, st);
        chk(pslverr[0], 1'b1);
        chk(st, 32'h0);
        wrap_up;
    end
endmodule

`default_nettype wire

// [verif/twowire_link_asserts.sv]
/*
 * Concurrent checks on the two-wire link between master and amplifier target.
 * Assumes pclk samples the resolved lines and the bench instantiates it beside the link.
 */
`timescale 1ns/1ps
`default_nettype none

module twowire_link_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_dev_low_only: assert property (dev_sda_o == 1'b0)
        else $error("target drives sda high");
    a_host_low_only: assert property (!host_scl_o && !host_sda_o)
        else $error("master drives a line high");
    a_scl_from_host: assert property (!scl |-> host_scl_oe)
        else $error("scl low with no master pull");
    a_sda_has_driver: assert property (!sda |-> host_sda_oe || dev_sda_oe)
        else $error("sda low with no driver");
    // A target change while scl is high would read as a START or STOP.
    a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("target moved sda while scl high");
    a_start_scl_high: assert property (scl && $fell(sda) |-> $past(scl))
        else $error("start without scl held high");
    a_idle_after_stop: assert property (scl && $rose(sda) |=> !dev_sda_oe [*8])
        else $error("target drives sda after stop");
    a_release_bounded: assert property ($rose(dev_sda_oe) |-> ##[1:1000] !dev_sda_oe)
        else $error("target holds sda too long");
endmodule

`default_nettype wire
